// [hw/pcd_abs_cmp.sv]
// Magnitude of a signed value compared with an unsigned limit.
// Assumes the limit is narrower than the value.
`default_nettype none

module pcd_abs_cmp #(
    parameter int VAL_W = 32,
    parameter int LIM_W = 19,
    parameter bit INCL = 1'b1
) (
    input wire logic [VAL_W-1:0] value,
    input wire logic [LIM_W-1:0] limit,
    output logic hit
);
    logic [VAL_W-1:0] mag;
    logic [VAL_W-1:0] lim_ext;

    always_comb begin
        mag = value[VAL_W-1] ? VAL_W'(~value + 1'b1) : value;
        lim_ext = VAL_W'(limit);
        hit = INCL ? (mag <= lim_ext) : (mag < lim_ext);
    end
endmodule : pcd_abs_cmp

`default_nettype wire

// [hw/pcd_detector.sv]
// Positioning completion detector with an APB3 register slave.
// Assumes error, speed and command inputs are synchronous to pclk.
//
// Decided for this implementation: the register addresses and register access over APB.
`default_nettype none

module pcd_detector
    import pcd_pkg::*;
#(
    parameter logic [PRE_W-1:0] MS_TICKS = PRE_W'(MS_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ERR_W-1:0] pos_err,
    input wire logic [SPD_W-1:0] motor_speed,
    input wire logic pos_cmd_active,
    output logic completion,
    output logic zero_speed_flag
);

    ////////////////////////////////////////////////////////////////////////
    // State
    pcd_top_st_t st_q;
    pcd_top_st_t st_d;

    logic in_win;
    logic speed_slow;
    logic hold_active;
    logic hold_start;
    logic raw_done;
    logic mapped;
    logic wr_en;
    logic rd_setup;
    logic [31:0] rd_mux;
    logic [WIN_W-1:0] wr_win;
    logic [HOLD_W-1:0] wr_hold;
    logic [ZTHR_W-1:0] wr_zthr;

    ////////////////////////////////////////////////////////////////////////
    // Comparators
    pcd_abs_cmp #(
        .VAL_W(ERR_W),
        .LIM_W(WIN_W),
        .INCL(1'b1)
    ) u_win_cmp (
        .value(pos_err),
        .limit(st_q.window),
        .hit(in_win)
    );

    pcd_abs_cmp #(
        .VAL_W(SPD_W),
        .LIM_W(ZTHR_W),
        .INCL(1'b0)
    ) u_spd_cmp (
        .value(motor_speed),
        .limit(st_q.zthr),
        .hit(speed_slow)
    );

    pcd_hold_timer #(
        .TICKS(MS_TICKS)
    ) u_hold (
        .pclk(pclk),
        .presetn(presetn),
        .start(hold_start),
        .hold_ms(st_q.hold),
        .active(hold_active)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    always_comb begin
        mapped = (paddr == ADDR_WINDOW) || (paddr == ADDR_COND) ||
                 (paddr == ADDR_HOLD) || (paddr == ADDR_ZTHR) ||
                 (paddr == ADDR_STATUS);
        wr_en = psel && penable && pwrite && mapped;
        rd_setup = psel && !penable && !pwrite;
        pready = 1'b1;
        pslverr = psel && penable && !mapped;
        prdata = st_q.rdata;
        // Clamp writes into the legal ranges
        wr_win = (pwdata > 32'(WIN_MAX)) ? WIN_MAX : pwdata[WIN_W-1:0]; // R1
        wr_hold = (pwdata > 32'(HOLD_MAX)) ? HOLD_MAX : pwdata[HOLD_W-1:0]; // R6
        if (pwdata > 32'(ZTHR_MAX)) begin
            wr_zthr = ZTHR_MAX; // R7
        end else if (pwdata < 32'(ZTHR_MIN)) begin
            wr_zthr = ZTHR_MIN; // R7
        end else begin
            wr_zthr = pwdata[ZTHR_W-1:0];
        end
    end

    always_comb begin
        rd_mux = '0;
        case (paddr)
            ADDR_WINDOW: rd_mux = 32'(st_q.window);
            ADDR_COND: rd_mux = 32'(st_q.cond);
            ADDR_HOLD: rd_mux = 32'(st_q.hold);
            ADDR_ZTHR: rd_mux = 32'(st_q.zthr);
            ADDR_STATUS: begin
                rd_mux[ST_DONE] = st_q.done;
                rd_mux[ST_ZSF] = st_q.zsf;
                rd_mux[ST_INWIN] = in_win;
                rd_mux[ST_LATCH] = st_q.latch;
                rd_mux[ST_CMD] = pos_cmd_active;
            end
            default: rd_mux = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion condition
    always_comb begin
        case (st_q.cond)
            COND_WINDOW: raw_done = in_win; // R2
            COND_NO_CMD: raw_done = in_win && !pos_cmd_active; // R3
            COND_ZERO_SPD: raw_done = st_q.zsf && in_win && !pos_cmd_active; // R4
            COND_LATCH: raw_done = !pos_cmd_active && (st_q.latch || in_win); // R5
            default: raw_done = 1'b0;
        endcase
        hold_start = raw_done && !st_q.done; // R8
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.zsf = speed_slow; // R7
        st_d.done = raw_done || hold_active; // R8
        // Latch clears when a command begins or the mode changes
        if (st_q.cond != COND_LATCH || pos_cmd_active) begin
            st_d.latch = 1'b0; // R5
        end else if (in_win) begin
            st_d.latch = 1'b1; // R5
        end
        if (rd_setup) begin
            st_d.rdata = rd_mux;
        end
        if (wr_en) begin
            case (paddr)
                ADDR_WINDOW: st_d.window = wr_win; // R1
                ADDR_COND: st_d.cond = pcd_cond_t'(pwdata[1:0]); // R2
                ADDR_HOLD: st_d.hold = wr_hold; // R6
                ADDR_ZTHR: st_d.zthr = wr_zthr; // R7
                default: st_d.rdata = st_q.rdata;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{
                window: WIN_RST, // R1
                cond: COND_WINDOW, // R2
                hold: HOLD_RST, // R6
                zthr: ZTHR_RST, // R7
                latch: 1'b0,
                done: 1'b0,
                zsf: 1'b0,
                rdata: 32'h0000_0000
            };
        end else begin
            st_q <= st_d;
        end
    end

    assign completion = st_q.done;
    assign zero_speed_flag = st_q.zsf;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    win_range_a: assert property ( // R1
        st_q.window <= WIN_MAX
    ) else $error("window above its maximum");

    win_mode_a: assert property ( // R2
        st_q.cond == COND_WINDOW && in_win |=> completion
    ) else $error("window mode did not assert completion");

    cmd_block_a: assert property ( // R3
        st_q.cond == COND_NO_CMD && pos_cmd_active && !hold_active |=> !completion
    ) else $error("completion during a command in mode 1");

    zero_need_a: assert property ( // R4
        st_q.cond == COND_ZERO_SPD && !zero_speed_flag && !hold_active |=> !completion
    ) else $error("completion without zero speed in mode 2");

    latch_hold_a: assert property ( // R5
        st_q.cond == COND_LATCH && st_q.latch && !pos_cmd_active |=> completion
    ) else $error("latched completion dropped without a command");

    latch_clear_a: assert property ( // R5
        pos_cmd_active |=> !st_q.latch
    ) else $error("latch survived a command");

    hold_range_a: assert property ( // R6
        st_q.hold <= HOLD_MAX
    ) else $error("hold time above its maximum");

    zthr_range_a: assert property ( // R7
        st_q.zthr >= ZTHR_MIN && st_q.zthr <= ZTHR_MAX
    ) else $error("zero speed threshold out of range");

    zero_flag_a: assert property ( // R7
        speed_slow |=> zero_speed_flag ##0 $past(speed_slow)
    ) else $error("zero speed flag missed a slow speed");

    hold_start_a: assert property ( // R8
        $rose(completion) && $past(st_q.hold) != '0 |-> hold_active
    ) else $error("hold timer not started with completion");

    hold_keep_a: assert property ( // R8
        hold_active |=> completion
    ) else $error("completion dropped during hold");

    apb_err_a: assert property (
        psel && penable && !mapped |-> pslverr && pready
    ) else $error("unmapped access not flagged");

    win_clear_a: assert property ( // R2
        st_q.cond == COND_WINDOW && !in_win && !hold_active |=> !completion
    ) else $error("completion outside the window in mode 0");

    cmd_idle_a: assert property ( // R3
        st_q.cond == COND_NO_CMD && in_win && !pos_cmd_active |=> completion
    ) else $error("no completion while idle in window in mode 1");

    zero_done_a: assert property ( // R4
        st_q.cond == COND_ZERO_SPD && zero_speed_flag && in_win && !pos_cmd_active
            |=> completion
    ) else $error("no completion at zero speed in window in mode 2");

    latch_set_a: assert property ( // R5
        st_q.cond == COND_LATCH && in_win && !pos_cmd_active |=> st_q.latch && completion
    ) else $error("latch not set in window in mode 3");

    latch_mode_a: assert property ( // R5
        st_q.cond != COND_LATCH |=> !st_q.latch
    ) else $error("latch set outside mode 3");

    latch_cmd_a: assert property ( // R5
        st_q.cond == COND_LATCH && pos_cmd_active && !hold_active |=> !completion
    ) else $error("completion during a command in mode 3");

    zero_clear_a: assert property ( // R7
        !speed_slow |=> !zero_speed_flag
    ) else $error("zero speed flag set at speed");

    hold_load_a: assert property ( // R8
        hold_start && st_q.hold != '0 |=> hold_active
    ) else $error("hold timer not loaded");

    hold_none_a: assert property ( // R8
        !raw_done && !hold_active |=> !completion
    ) else $error("completion without condition or hold");

    cond_write_a: assert property ( // R2
        wr_en && paddr == ADDR_COND |=> st_q.cond == $past(pwdata[1:0])
    ) else $error("condition write lost");

    win_write_a: assert property ( // R1
        wr_en && paddr == ADDR_WINDOW |=>
            st_q.window == (($past(pwdata) > 32'(WIN_MAX)) ?
                WIN_MAX : $past(pwdata[WIN_W-1:0]))
    ) else $error("window write not clamped");

    hold_write_a: assert property ( // R6
        wr_en && paddr == ADDR_HOLD |=>
            st_q.hold == (($past(pwdata) > 32'(HOLD_MAX)) ?
                HOLD_MAX : $past(pwdata[HOLD_W-1:0]))
    ) else $error("hold write not clamped");

    bad_write_a: assert property (
        psel && penable && pwrite && !mapped |=>
            $stable(st_q.window) && $stable(st_q.hold) && $stable(st_q.zthr)
    ) else $error("unmapped write changed a register");

    status_read_a: assert property (
        rd_setup && paddr == ADDR_STATUS |=> prdata[ST_DONE] == $past(completion)
    ) else $error("status read lost completion");

    cmd_mode_c: cover property (
        st_q.cond == COND_NO_CMD && $fell(pos_cmd_active) ##1 completion
    );

    hold_clamp_c: cover property (
        wr_en && paddr == ADDR_HOLD && pwdata > 32'(HOLD_MAX)
    );

    latch_seen_c: cover property (
        st_q.cond == COND_LATCH && st_q.latch && !in_win ##1 completion
    );

    hold_ext_c: cover property (
        hold_active && !raw_done ##1 completion
    );

    zero_mode_c: cover property (
        st_q.cond == COND_ZERO_SPD && $rose(completion)
    );

endmodule : pcd_detector

`default_nettype wire

// [hw/pcd_hold_timer.sv]
// Millisecond hold timer, restarted by a start pulse.
// Assumes the start pulse lasts one cycle.
`default_nettype none

module pcd_hold_timer
    import pcd_pkg::*;
#(
    parameter logic [PRE_W-1:0] TICKS = PRE_W'(MS_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [HOLD_W-1:0] hold_ms,
    output logic active
);
    pcd_hold_st_t st_q;
    pcd_hold_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (start) begin
            // Prescaler restarts so the first step is a full ms
            st_d.ms = hold_ms; // R8
            st_d.pre = TICKS - 1'b1;
        end else if (st_q.ms != '0) begin
            if (st_q.pre == '0) begin
                st_d.pre = TICKS - 1'b1;
                st_d.ms = st_q.ms - 1'b1; // R6
            end else begin
                st_d.pre = st_q.pre - 1'b1;
            end
        end
        active = st_q.ms != '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : pcd_hold_timer

`default_nettype wire

// [hw/pcd_pkg.sv]
// Constants and types for the positioning completion detector.
// Assumes a 50 MHz pclk and an APB3 master with 32-bit data.
// Summary of operation
// R1: A completion window in command units, 0 to 262144, resets to 10.
// R2: Condition selector 0 to 3, resets to 0; at 0 done follows the error being in window.
// R3: At 1 done needs the error in window and no position command arriving.
// R4: At 2 done needs zero speed, the error in window and no position command.
// R5: At 3 done sets on error in window with no command and holds until a command begins.
// R6: A hold time in 1 ms steps, 0 to 30000, resets to 0.
// R7: The zero speed flag is set below a speed threshold of 10 to 20000, reset 50.
// R8: A nonzero hold keeps done asserted at least that many ms after it turns on.
`default_nettype none

package pcd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_WINDOW = 8'h00;
    localparam logic [7:0] ADDR_COND = 8'h04;
    localparam logic [7:0] ADDR_HOLD = 8'h08;
    localparam logic [7:0] ADDR_ZTHR = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // Field widths, ranges and reset values
    localparam int WIN_W = 19;
    localparam int HOLD_W = 15;
    localparam int ZTHR_W = 15;
    localparam int ERR_W = 32;
    localparam int SPD_W = 16;
    localparam int PRE_W = 32;
    localparam logic [18:0] WIN_MAX = 19'h40000;
    localparam logic [18:0] WIN_RST = 19'h0000A;
    localparam logic [14:0] HOLD_MAX = 15'h7530;
    localparam logic [14:0] HOLD_RST = 15'h0000;
    localparam logic [14:0] ZTHR_MIN = 15'h000A;
    localparam logic [14:0] ZTHR_MAX = 15'h4E20;
    localparam logic [14:0] ZTHR_RST = 15'h0032;

    // Status bit positions
    localparam int ST_DONE = 0;
    localparam int ST_ZSF = 1;
    localparam int ST_INWIN = 2;
    localparam int ST_LATCH = 3;
    localparam int ST_CMD = 4;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int HOLD_STEP_NS = 1000000;
    localparam int MS_CYCLES = HOLD_STEP_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        COND_WINDOW,
        COND_NO_CMD,
        COND_ZERO_SPD,
        COND_LATCH
    } pcd_cond_t;

    typedef struct packed {
        logic [WIN_W-1:0] window;
        pcd_cond_t cond;
        logic [HOLD_W-1:0] hold;
        logic [ZTHR_W-1:0] zthr;
        logic latch;
        logic done;
        logic zsf;
        logic [31:0] rdata;
    } pcd_top_st_t;

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [HOLD_W-1:0] ms;
    } pcd_hold_st_t;

endpackage : pcd_pkg

`default_nettype wire

// [testbench/pcd_host_model.sv]
// Host side model: drives position error, speed and command activity.
// Assumes calls come right after a rising pclk edge.
`default_nettype none

module pcd_host_model
    import pcd_pkg::*;
(
    input wire logic pclk,
    output logic [ERR_W-1:0] pos_err,
    output logic [SPD_W-1:0] motor_speed,
    output logic pos_cmd_active
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pos_err = '0;
        motor_speed = '0;
        pos_cmd_active = 1'b0;
    end

    task automatic drive(input logic [31:0] e, input logic [15:0] s, input logic c);
        pos_err <= e;
        motor_speed <= s;
        pos_cmd_active <= c;
    endtask : drive

    // A command in flight for n cycles, then settling at error fe
    task automatic move(input int n, input logic [31:0] fe);
        pos_cmd_active <= 1'b1;
        pos_err <= 32'h000003E8;
        motor_speed <= 16'h01F4;
        repeat (n) @(posedge pclk);
        pos_cmd_active <= 1'b0;
        pos_err <= fe;
        motor_speed <= 16'h0000;
    endtask : move

endmodule : pcd_host_model

`default_nettype wire

// [testbench/tb_positioning_completion_detector.sv]
// Testbench for the positioning completion detector.
// Assumes pcd_pkg and the host model; the APB master lives here.
`default_nettype none

module tb_positioning_completion_detector
    import pcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, pos_err;
    logic [15:0] motor_speed;
    logic pready, pslverr, completion, zero_speed_flag, pos_cmd_active;
    int n_errors = 0;
    int samples_checked = 0;

    always #10 pclk = ~pclk;

    pcd_detector #(.MS_TICKS(32'h0000000A)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pos_err(pos_err),
        .motor_speed(motor_speed), .pos_cmd_active(pos_cmd_active),
        .completion(completion), .zero_speed_flag(zero_speed_flag));

    pcd_host_model u_host (.pclk(pclk), .pos_err(pos_err), .motor_speed(motor_speed),
        .pos_cmd_active(pos_cmd_active));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string m);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        cmp(r, x, m);
    endtask : rchk

    task automatic chk(input logic c, input string m);
        repeat (3) @(posedge pclk);
        cmp({31'h0, completion}, {31'h0, c}, m);
    endtask : chk

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rchk(ADDR_WINDOW, 32'h0000000A, "window reset");
        rchk(ADDR_COND, 32'h00000000, "cond reset");
        rchk(ADDR_HOLD, 32'h00000000, "hold reset");
        rchk(ADDR_ZTHR, 32'h00000032, "zthr reset");
        apb(1'b0, 8'h14, 32'h00000000, r, e);
        cmp({31'h0, e}, 32'h00000001, "unmapped err");
        cmp({31'h0, pready}, 32'h00000001, "ready");
        wr(ADDR_WINDOW, 32'h0007FFFF);
        rchk(ADDR_WINDOW, 32'h00040000, "window max");
        wr(ADDR_HOLD, 32'h0000FFFF);
        rchk(ADDR_HOLD, 32'h00007530, "hold max");
        wr(ADDR_ZTHR, 32'h00000001);
        rchk(ADDR_ZTHR, 32'h0000000A, "zthr min");
        wr(ADDR_WINDOW, 32'h0000000A);
        wr(ADDR_HOLD, 32'h00000000);
        wr(ADDR_ZTHR, 32'h00000032);
        $display("test regs done");
    endtask : t_regs

    task automatic t_mode0;
        logic [31:0] e[4] = '{32'h0000000A, 32'h0000000B, 32'hFFFFFFF6, 32'hFFFFFFF5};
        logic x[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            u_host.drive(e[i], 16'h0000, 1'b1);
            chk(x[i], "mode0");
        end
        $display("test mode0 done");
    endtask : t_mode0

    task automatic t_mode12;
        wr(ADDR_COND, 32'h00000001);
        u_host.drive(32'h00000000, 16'h0000, 1'b1);
        chk(1'b0, "mode1 cmd");
        u_host.drive(32'h00000000, 16'h0000, 1'b0);
        chk(1'b1, "mode1 idle");
        wr(ADDR_COND, 32'h00000002);
        u_host.drive(32'h00000000, 16'h0032, 1'b0);
        chk(1'b0, "mode2 moving");
        cmp({31'h0, zero_speed_flag}, 32'h00000000, "zsf at thr");
        u_host.drive(32'h00000000, 16'hFFCF, 1'b0);
        chk(1'b1, "mode2 still");
        cmp({31'h0, zero_speed_flag}, 32'h00000001, "zsf below");
        u_host.drive(32'h00000000, 16'h0031, 1'b1);
        chk(1'b0, "mode2 cmd");
        $display("test mode12 done");
    endtask : t_mode12

    task automatic t_mode3;
        wr(ADDR_COND, 32'h00000003);
        u_host.drive(32'h00000000, 16'h0000, 1'b0);
        chk(1'b1, "mode3 set");
        u_host.drive(32'h00001388, 16'h0000, 1'b0);
        chk(1'b1, "mode3 latched");
        rchk(ADDR_STATUS, 32'h0000000B, "mode3 status");
        u_host.drive(32'h00001388, 16'h0000, 1'b1);
        chk(1'b0, "mode3 new cmd");
        u_host.move(4, 32'h00000003);
        chk(1'b1, "mode3 settled");
        wr(ADDR_COND, 32'h00000000);
        $display("test mode3 done");
    endtask : t_mode3

    task automatic t_hold;
        int n;
        u_host.drive(32'h00001388, 16'h0000, 1'b0);
        repeat (3) @(posedge pclk);
        wr(ADDR_HOLD, 32'h00000002);
        u_host.drive(32'h00000000, 16'h0000, 1'b0);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (completion !== 1'b1 && n < 10);
        cmp({31'h0, completion}, 32'h00000001, "hold rise");
        u_host.drive(32'h00001388, 16'h0000, 1'b0);
        repeat (18) begin
            @(posedge pclk);
            cmp({31'h0, completion}, 32'h00000001, "hold kept");
        end
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (completion !== 1'b0 && n < 15);
        cmp({31'h0, completion}, 32'h00000000, "hold end");
        $display("test hold done");
    endtask : t_hold

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_mode0();
        t_mode12();
        t_mode3();
        t_hold();
        test_done();
    end

    initial begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        test_done();
    end

endmodule : tb_positioning_completion_detector

`default_nettype wire
